// [common/ipc_regs.vh]
/*
 * Timing constants and state codes for the primary IDE command and strobe engine.
 * Assumes a 100 MHz mclk; included by its bare name from the strobe engine rtl only.
 */
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

`define IPC_CLK_MHZ         100
`define IPC_T_SETUP_NS      30
`define IPC_T_ACTIVE_NS     90
`define IPC_T_RECOVER_NS    60
`define IPC_T_STROBE_NS     30
// counts rounded up for a 10 ns mclk; redo them when the clock changes
`define IPC_SETUP_CYC       4'h3
`define IPC_ACTIVE_CYC      4'h9
`define IPC_RECOVER_CYC     4'h6
`define IPC_STROBE_CYC      4'h3

`define IPC_ST_IDLE         3'h0
`define IPC_ST_SETUP        3'h1
`define IPC_ST_ACTIVE       3'h2
`define IPC_ST_RECOVER      3'h3
`define IPC_ST_BURST        3'h4
`define IPC_ST_STOP         3'h5

`endif

// [rtl/ipc_sync2.v]
/*
 * Two-flop synchroniser, one generate stage per bit.
 * Assumes inputs come from pins outside the mclk domain.
 */
`timescale 1ns/100ps
module ipc_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // first stage feeds only the second
            always @(posedge mclk) begin
                if (reset) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate
endmodule // ipc_sync2

// [rtl/ipc_strobe_engine.v]
/*
 * Primary IDE channel command and strobe engine: conventional PIO/DMA cycles
 * and synchronous DMA bursts on the read/write command and channel-ready pins.
 * Assumes a user-side requester on mclk and an ATA drive on the pins.
 */
// Contract
// - conventional read: assert read command, capture data at its negation
// - cycle addressed by chip selects plus address, or by DMA acknowledge
// - sync DMA read: read pin is ready-low, negated to pause drive
// - sync DMA write: read pin toggles, drive latches every edge
// - sync DMA: write pin is STOP, asserted to end transfer
// - sync DMA read: channel-ready toggles, host captures on both edges
// - pins go to primary or primary-master connector per configuration
// - read pin high in reset, after reset and in suspend
// - write pin high in and after reset, released in suspend
`timescale 1ns/100ps
`include "ipc_regs.vh"
module ipc_strobe_engine (
    input  wire        mclk,
    input  wire        reset,
    input  wire        suspend,
    input  wire        masterSlaveConfig,
    output reg         connectorIsMaster,
    input  wire        cmdValid,
    output wire        cmdReady,
    input  wire        cmdWrite,
    input  wire        cmdDma,
    input  wire        cmdCtrlBlock,
    input  wire [2:0]  cmdAddr,
    input  wire [15:0] cmdWriteData,
    output reg         rspValid,
    output reg  [15:0] rspData,
    input  wire        burstStart,
    input  wire        burstWrite,
    input  wire        burstStop,
    input  wire        burstPause,
    output reg         burstActive,
    input  wire        txValid,
    output wire        txReady,
    input  wire [15:0] txData,
    output reg         rxValid,
    output reg  [15:0] rxData,
    output reg         primary_read_cmd_n,
    output reg         primary_write_cmd_n,
    output reg         primary_write_cmd_oe,
    input  wire        primary_channel_ready,
    input  wire        primary_dma_req,
    output reg  [2:0]  primary_disk_addr,
    output reg         primary_cmd_block_sel_n,
    output reg         primary_ctrl_block_sel_n,
    output reg         primary_dma_ack_n,
    input  wire [15:0] primary_disk_data_in,
    output reg  [15:0] primary_disk_data_out,
    output reg         primary_disk_data_oe
);
    localparam [3:0] SETUP_CYC   = `IPC_SETUP_CYC;
    localparam [3:0] ACTIVE_CYC  = `IPC_ACTIVE_CYC;
    localparam [3:0] RECOVER_CYC = `IPC_RECOVER_CYC;
    localparam [3:0] STROBE_CYC  = `IPC_STROBE_CYC;

    reg  [2:0]  state;
    reg  [3:0]  count;
    reg         isWrite;
    reg         isDma;
    reg         toggleDue;
    reg         rdyPrev;
    wire [17:0] syncBus;
    wire        rdySync;
    wire        reqSync;
    wire [15:0] dataSync;

    // pins, clock domain crossing before any logic
    ipc_sync2 #(.WIDTH(18)) u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .asyncIn ({primary_channel_ready, primary_dma_req, primary_disk_data_in}),
        .syncOut (syncBus)
    );
    assign rdySync  = syncBus[17];
    assign reqSync  = syncBus[16];
    assign dataSync = syncBus[15:0];

    assign cmdReady = (state == `IPC_ST_IDLE) && !suspend;
    assign txReady  = (state == `IPC_ST_BURST) && isWrite && !toggleDue && !rdySync
                      && (count == 4'h0);

    always @(posedge mclk) begin
        if (reset) begin
            state                    <= `IPC_ST_IDLE;
            count                    <= 4'h0;
            isWrite                  <= 1'b0;
            isDma                    <= 1'b0;
            toggleDue                <= 1'b0;
            rdyPrev                  <= 1'b0;
            connectorIsMaster        <= 1'b0;
            rspValid                 <= 1'b0;
            rspData                  <= 16'h0000;
            burstActive              <= 1'b0;
            rxValid                  <= 1'b0;
            rxData                   <= 16'h0000;
            primary_read_cmd_n       <= 1'b1;
            primary_write_cmd_n      <= 1'b1;
            primary_write_cmd_oe     <= 1'b1;
            primary_disk_addr        <= 3'h0;
            primary_cmd_block_sel_n  <= 1'b1;
            primary_ctrl_block_sel_n <= 1'b1;
            primary_dma_ack_n        <= 1'b1;
            primary_disk_data_out    <= 16'h0000;
            primary_disk_data_oe     <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            rxValid  <= 1'b0;
            rdyPrev  <= rdySync;
            connectorIsMaster <= masterSlaveConfig;
            primary_write_cmd_oe <= !(suspend && state == `IPC_ST_IDLE);
            if (count != 4'h0) begin
                count <= count - 4'h1;
            end
            case (state)
                `IPC_ST_IDLE: begin
                    primary_read_cmd_n  <= 1'b1;
                    primary_write_cmd_n <= 1'b1;
                    if (suspend) begin
                        primary_read_cmd_n <= 1'b1;
                    end else if (cmdValid) begin
                        isWrite <= cmdWrite;
                        isDma   <= cmdDma;
                        // select by chip select or acknowledge
                        if (cmdDma) begin
                            primary_dma_ack_n <= 1'b0;
                        end else begin
                            primary_disk_addr        <= cmdAddr;
                            primary_cmd_block_sel_n  <= cmdCtrlBlock;
                            primary_ctrl_block_sel_n <= !cmdCtrlBlock;
                        end
                        primary_disk_data_out <= cmdWriteData;
                        primary_disk_data_oe  <= cmdWrite;
                        count <= SETUP_CYC;
                        state <= `IPC_ST_SETUP;
                    end else if (burstStart && reqSync) begin
                        isWrite           <= burstWrite;
                        toggleDue         <= 1'b0;
                        burstActive       <= 1'b1;
                        primary_dma_ack_n <= 1'b0;
                        primary_disk_data_oe <= burstWrite;
                        count <= STROBE_CYC;
                        state <= `IPC_ST_BURST;
                    end
                end
                `IPC_ST_SETUP: begin
                    if (count == 4'h0) begin
                        if (isWrite) begin
                            primary_write_cmd_n <= 1'b0;
                        end else begin
                            // read command lets drive drive bus
                            primary_read_cmd_n <= 1'b0;
                        end
                        count <= ACTIVE_CYC;
                        state <= `IPC_ST_ACTIVE;
                    end
                end
                `IPC_ST_ACTIVE: begin
                    if (count == 4'h0 && rdySync) begin
                        primary_read_cmd_n  <= 1'b1;
                        primary_write_cmd_n <= 1'b1;
                        if (!isWrite) begin
                            rspData <= dataSync;
                        end
                        rspValid <= 1'b1;
                        count <= RECOVER_CYC;
                        state <= `IPC_ST_RECOVER;
                    end
                end
                `IPC_ST_RECOVER: begin
                    primary_disk_data_oe     <= 1'b0;
                    primary_cmd_block_sel_n  <= 1'b1;
                    primary_ctrl_block_sel_n <= 1'b1;
                    primary_dma_ack_n        <= 1'b1;
                    if (count == 4'h0) begin
                        state <= `IPC_ST_IDLE;
                    end
                end
                `IPC_ST_BURST: begin
                    primary_write_cmd_n <= 1'b0;
                    if (isWrite) begin
                        // data set up one cycle before its edge
                        if (txValid && txReady) begin
                            primary_disk_data_out <= txData;
                            toggleDue <= 1'b1;
                        end else if (toggleDue) begin
                            primary_read_cmd_n <= !primary_read_cmd_n;
                            toggleDue <= 1'b0;
                            count <= STROBE_CYC;
                        end
                    end else begin
                        primary_read_cmd_n <= burstPause;
                        if (rdySync != rdyPrev) begin
                            rxData  <= dataSync;
                            rxValid <= 1'b1;
                        end
                    end
                    // pending toggle finishes first so no word is lost
                    if ((burstStop || !reqSync) && !toggleDue && !(txValid && txReady)) begin
                        state <= `IPC_ST_STOP;
                    end
                end
                `IPC_ST_STOP: begin
                    primary_write_cmd_n <= 1'b1;
                    if (!isWrite) begin
                        primary_read_cmd_n <= 1'b1;
                    end
                    if (!reqSync) begin
                        primary_read_cmd_n   <= 1'b1;
                        primary_dma_ack_n    <= 1'b1;
                        primary_disk_data_oe <= 1'b0;
                        burstActive          <= 1'b0;
                        state <= `IPC_ST_IDLE;
                    end
                end
                default: begin
                    state <= `IPC_ST_IDLE;
                end
            endcase
        end
    end
endmodule // ipc_strobe_engine

// [dv/ipc_strobe_engine_asserts.sv]
/* checker for the primary command and strobe engine
   assumes binding to ipc_strobe_engine, one mclk domain */
`timescale 1ns/100ps
module ipc_strobe_engine_asserts (
    input wire logic mclk, reset, suspend, burstWrite, burstStop, burstPause, burstActive,
    input wire logic txValid, txReady, rxValid, rspValid, primary_read_cmd_n,
    input wire logic primary_write_cmd_n, primary_write_cmd_oe, primary_channel_ready,
    input wire logic primary_cmd_block_sel_n, primary_ctrl_block_sel_n, primary_dma_ack_n,
    input wire logic [15:0] txData, rspData, primary_disk_data_in, primary_disk_data_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire noSel = primary_cmd_block_sel_n & primary_ctrl_block_sel_n & primary_dma_ack_n;
    property p_rst; disable iff (1'h0)
        reset |=> primary_read_cmd_n && primary_write_cmd_n && primary_write_cmd_oe; endproperty
    property p_sel; !primary_read_cmd_n || (!primary_write_cmd_n && primary_write_cmd_oe)
        |-> !noSel; endproperty
    property p_rd; $rose(primary_read_cmd_n) && !burstActive && !$past(burstActive)
        |-> rspValid && rspData == $past(primary_disk_data_in, 3); endproperty
    property p_ext; !primary_channel_ready [*4] ##0 (!primary_read_cmd_n && !burstActive)
        |=> !primary_read_cmd_n; endproperty
    property p_stop; burstActive && burstStop |-> ##[1:3] primary_write_cmd_n; endproperty
    property p_pause; burstActive && !burstWrite && !primary_write_cmd_n ##1
        burstActive && !primary_write_cmd_n |-> primary_read_cmd_n == $past(burstPause); endproperty
    property p_tx; txValid && txReady |=> primary_disk_data_out == $past(txData)
        ##1 primary_read_cmd_n != $past(primary_read_cmd_n); endproperty
    property p_rx; burstActive && !burstWrite && !primary_write_cmd_n
        && $changed(primary_channel_ready) |-> ##[2:4] rxValid; endproperty
    property p_susp; (suspend && noSel) [*8] |-> !primary_write_cmd_oe && primary_read_cmd_n;
    endproperty
    a_rst: assert property (p_rst) else $error("pin levels wrong in reset");
    a_sel: assert property (p_sel) else $error("command without selection");
    a_rd: assert property (p_rd) else $error("read data not taken at negation");
    a_ext: assert property (p_ext) else $error("read ended while not ready");
    a_stop: assert property (p_stop) else $error("stop level missing");
    a_pause: assert property (p_pause) else $error("ready level wrong in read burst");
    a_tx: assert property (p_tx) else $error("write strobe did not toggle");
    a_rx: assert property (p_rx) else $error("read strobe edge lost");
    a_susp: assert property (p_susp) else $error("pin levels wrong in suspend");
    c_rsp: cover property (rspValid);
    c_rx: cover property (rxValid);
    c_tx: cover property (txValid && txReady);
endmodule // ipc_strobe_engine_asserts
bind ipc_strobe_engine ipc_strobe_engine_asserts u_chk (.*);

// [dv/ipc_drive_model.sv]
/* behavioural drive on the primary connector
   assumes the bench picks mode, stall and strobe run */
`timescale 1ns/100ps
module ipc_drive_model (
    input wire logic rdN, wrN, ackN, pause, wrBurst, strobeOn,
    input wire logic [15:0] hostData,
    output logic rdy,
    output logic [15:0] driveData, lastWr,
    output int edges
);
    logic strb = 1'h1;
    logic [15:0] word = 16'hA5C3;
    initial edges = 0;
    assign rdy = strobeOn ? strb : (wrBurst ? pause : !pause);
    // released bus shows a changed pattern
    assign driveData = (!rdN || strobeOn) ? word : ~word;
    always @(posedge wrN) if (!wrBurst) lastWr = hostData;
    always @(rdN) if (wrBurst && !ackN) begin
        edges++;
        lastWr = hostData;
    end
    always begin
        wait (strobeOn);
        #20 strb = !strb;
        #20 word = word + 16'h1111;
    end
endmodule // ipc_drive_model

// [dv/testbench.sv]
/* self-checking bench for the command and strobe engine
   assumes the drive model and the bound checker */
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module testbench;
    logic mclk, reset, suspend, masterSlaveConfig, cmdValid, cmdWrite, cmdDma, cmdCtrlBlock;
    logic burstStart, burstWrite, burstStop, burstPause, txValid, primary_dma_req;
    logic pause, wrBurst, strobeOn;
    logic [2:0] cmdAddr;
    logic [15:0] cmdWriteData, txData, expWord;
    wire connectorIsMaster, cmdReady, rspValid, burstActive, txReady, rxValid;
    wire primary_read_cmd_n, primary_write_cmd_n, primary_write_cmd_oe, primary_channel_ready;
    wire primary_cmd_block_sel_n, primary_ctrl_block_sel_n, primary_dma_ack_n;
    wire primary_disk_data_oe;
    wire [2:0] primary_disk_addr;
    wire [15:0] rspData, rxData, primary_disk_data_in, primary_disk_data_out, lastWr;
    int edges, i, num_errors = 0, check_count = 0;
    ipc_strobe_engine DUT (.*);
    ipc_drive_model DRV (.rdN(primary_read_cmd_n), .wrN(primary_write_cmd_n),
        .ackN(primary_dma_ack_n), .pause, .wrBurst, .strobeOn,
        .hostData(primary_disk_data_out), .rdy(primary_channel_ready),
        .driveData(primary_disk_data_in), .lastWr, .edges);
    task close_out;
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmd(input logic w, d, c, input logic [2:0] a, input logic [15:0] wd);
        for (i = 0; i < 50 && cmdReady !== 1'h1; i++) @(negedge mclk);
        {cmdWrite, cmdDma, cmdCtrlBlock, cmdAddr, cmdWriteData} = {w, d, c, a, wd};
        cmdValid = 1'h1;
        @(negedge mclk) cmdValid = 1'h0;
        for (i = 0; i < 300 && rspValid !== 1'h1; i++) @(negedge mclk);
        `CHK("cmd answer", 1'h1, rspValid)
    endtask
    task tx(input logic [15:0] d);
        @(negedge mclk) txData = d;
        txValid = 1'h1;
        for (i = 0; i < 50 && txReady !== 1'h1; i++) @(negedge mclk);
        `CHK("tx accepted", 1'h1, txReady)
        @(negedge mclk) txValid = 1'h0;
    endtask
    task burst_go(input logic w);
        primary_dma_req = 1'h1;
        burstWrite = w;
        burstStart = 1'h1;
        for (i = 0; i < 20 && burstActive !== 1'h1; i++) @(negedge mclk);
        burstStart = 1'h0;
        `CHK("dma ack", 1'h0, primary_dma_ack_n)
    endtask
    task burst_end;
        burstStop = 1'h1;
        repeat (3) @(negedge mclk);
        `CHK("stop level", 1'h1, primary_write_cmd_n)
        primary_dma_req = 1'h0;
        for (i = 0; i < 20 && burstActive !== 1'h0; i++) @(negedge mclk);
        burstStop = 1'h0;
        `CHK("ack released", 1'h1, primary_dma_ack_n)
    endtask
    task t_read_stall;
        pause = 1'h1;
        fork cmd(1'h0, 1'h0, 1'h0, 3'h5, 16'h0000); begin
            repeat (40) @(negedge mclk);
            `CHK("read held", 1'h0, primary_read_cmd_n)
            pause = 1'h0;
        end join
        `CHK("read data", 16'hA5C3, rspData)
        `CHK("read addr", 3'h5, primary_disk_addr)
        `CHK("cmd select", 1'h0, primary_cmd_block_sel_n)
        `CHK("read bus free", 1'h0, primary_disk_data_oe)
    endtask
    task t_write_dma;
        cmd(1'h1, 1'h0, 1'h1, 3'h6, 16'h5AA5);
        `CHK("ctrl select", 1'h0, primary_ctrl_block_sel_n)
        `CHK("drive latch", 16'h5AA5, lastWr)
        `CHK("write bus driven", 1'h1, primary_disk_data_oe)
        cmd(1'h0, 1'h1, 1'h0, 3'h0, 16'h0000);
        `CHK("dma read ack", 1'h0, primary_dma_ack_n)
        `CHK("dma data", 16'hA5C3, rspData)
    endtask
    task t_wburst;
        wrBurst = 1'h1;
        burst_go(1'h1);
        for (int k = 1; k <= 4; k++) begin
            if (k == 3) begin
                pause = 1'h1;
                repeat (6) @(negedge mclk);
                `CHK("drive paused", 1'h0, txReady)
                pause = 1'h0;
            end
            tx(16'h1000 + k[15:0]);
        end
        repeat (6) @(negedge mclk);
        `CHK("strobe edges", 4, edges)
        `CHK("last word", 16'h1004, lastWr)
        burst_end;
        wrBurst = 1'h0;
    endtask
    task t_rburst;
        burst_go(1'h0);
        strobeOn = 1'h1;
        expWord = 16'hA5C3;
        repeat (4) begin
            for (i = 0; i < 20 && rxValid !== 1'h1; i++) @(negedge mclk);
            `CHK("rx strobe", 1'h1, rxValid)
            `CHK("rx word", expWord, rxData)
            expWord = expWord + 16'h1111;
            @(negedge mclk);
        end
        strobeOn = 1'h0;
        burstPause = 1'h1;
        repeat (2) @(negedge mclk);
        `CHK("ready negated", 1'h1, primary_read_cmd_n)
        burstPause = 1'h0;
        repeat (2) @(negedge mclk);
        `CHK("ready asserted", 1'h0, primary_read_cmd_n)
        burst_end;
    endtask
    task t_susp;
        suspend = 1'h1;
        masterSlaveConfig = 1'h1;
        repeat (10) @(negedge mclk);
        `CHK("write released", 1'h0, primary_write_cmd_oe)
        `CHK("read high", 1'h1, primary_read_cmd_n)
        `CHK("master route", 1'h1, connectorIsMaster)
        suspend = 1'h0;
        masterSlaveConfig = 1'h0;
        repeat (2) @(negedge mclk);
        `CHK("primary route", 1'h0, connectorIsMaster)
        `CHK("write driven", 1'h1, primary_write_cmd_oe)
    endtask
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200000;
        num_errors++;
        close_out;
    end
    initial begin
        {reset, suspend, masterSlaveConfig, cmdValid, cmdWrite, cmdDma, cmdCtrlBlock} = 7'h40;
        {burstStart, burstWrite, burstStop, burstPause, txValid, primary_dma_req} = 6'h00;
        {pause, wrBurst, strobeOn, cmdAddr, cmdWriteData, txData} = 38'h0;
        repeat (3) @(negedge mclk);
        `CHK("reset write", 1'h1, primary_write_cmd_n)
        `CHK("reset read", 1'h1, primary_read_cmd_n)
        reset = 1'h0;
        t_read_stall;
        t_write_dma;
        t_wburst;
        t_rburst;
        t_susp;
        close_out;
    end
endmodule // testbench
